// [ucfg_pkg.sv]
package ucfg_pkg;

	// configuration byte offsets
	localparam logic [7:0] OFF_MIN_GRANT   = 8'h3E;
	localparam logic [7:0] OFF_MAX_LATENCY = 8'h3F;
	localparam logic [7:0] OFF_TRDY_TO     = 8'h40;
	localparam logic [7:0] OFF_RETRY_LIM   = 8'h41;
	localparam logic [7:0] OFF_RELEASE     = 8'h60;
	localparam logic [7:0] OFF_FRAME_ADJ   = 8'h61;
	localparam logic [7:0] OFF_WAKE_LO     = 8'h62;
	localparam logic [7:0] OFF_WAKE_HI     = 8'h63;

	// reset and fixed values
	localparam logic [7:0]  RST_TRDY_TO     = 8'h00;
	localparam logic [7:0]  RST_RETRY_LIM   = 8'h80;
	localparam logic [7:0]  RST_FRAME_ADJ   = 8'h20;
	localparam logic [15:0] RST_WAKE_MASK   = 16'h0007;
	localparam logic [7:0]  RELEASE_NUMBER  = 8'h20;
	localparam logic [7:0]  MIN_GRANT_FS    = 8'h01;
	localparam logic [7:0]  MIN_GRANT_HS    = 8'h02;
	localparam logic [7:0]  MAX_LATENCY_FS  = 8'h2A;
	localparam logic [7:0]  MAX_LATENCY_HS  = 8'h10;
	localparam logic [7:0]  UNMAPPED_DATA   = 8'h00;

	// timing
	localparam int HINT_UNIT_NS   = 250;
	localparam int CLK_PERIOD_NS  = 5;
	localparam int HINT_UNIT_CYC  = (HINT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TRDY_ZERO_BITS = 5;
	localparam int TRDY_LIMIT_W   = 13;
	localparam int FRAME_ADJ_W    = 6;
	localparam int SOF_STEP_SHIFT = 4;
	localparam logic [15:0] SOF_BASE_LEN = 16'hE860;
	localparam logic [15:0] SOF_RST_LEN  = 16'hEA60;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ucfg_req_t;

	typedef struct packed {
		logic       ack;
		logic [7:0] rdata;
	} ucfg_rsp_t;

	typedef struct packed {
		logic data_phase_start;
		logic target_ready;
		logic retry_term;
		logic txn_end;
	} ucfg_pci_ev_t;

	typedef enum logic {TW_IDLE, TW_WAIT} ucfg_tw_t;

	typedef struct packed {
		logic [7:0]  trdy_to;
		logic [7:0]  retry_lim;
		logic [7:0]  frame_adj;
		logic [15:0] wake;
		ucfg_tw_t    tw;
		logic [13:0] wait_cnt;
		logic [8:0]  retry_cnt;
		logic        ue;
		ucfg_rsp_t   rsp;
	} ucfg_st_t;

	typedef struct packed {
		logic [15:0] cnt;
		logic [15:0] len;
		logic        sof;
	} ucfg_sof_st_t;

endpackage

// [ucfg_sof_timer.sv]
`timescale 1ns/1ps
module ucfg_sof_timer import ucfg_pkg::*; #(
	parameter int ADJ_W = FRAME_ADJ_W
) (
	input  wire logic             sys_clk,      // counter clock
	input  wire logic             rst_n,        // async reset, active low
	input  wire logic [ADJ_W-1:0] frame_adjust, // adjustment field
	output logic                  sof_pulse,    // one cycle at microframe start
	output logic [15:0]           frame_len     // length of the running microframe
);

	if (ADJ_W != FRAME_ADJ_W) begin : g_chk
		$error("ucfg_sof_timer: adjustment field must be six bits");
	end

	ucfg_sof_st_t st;
	ucfg_sof_st_t next_st;
	logic [15:0]  new_len;

	// each adjustment step is sixteen bit times
	assign new_len = SOF_BASE_LEN + 16'({frame_adjust, {SOF_STEP_SHIFT{1'b0}}});

	always_comb begin
		next_st     = st;
		next_st.sof = 1'b0;
		if (st.cnt == st.len - 16'h0001) begin
			next_st.cnt = 16'h0000;
			next_st.sof = 1'b1;
			// a new value takes effect at the next microframe boundary
			next_st.len = new_len;
		end else begin
			next_st.cnt = st.cnt + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st.cnt <= 16'h0000;
			st.len <= SOF_RST_LEN;
			st.sof <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign sof_pulse = st.sof;
	assign frame_len = st.len;

	property p_sof_len;
		@(posedge sys_clk) disable iff (!rst_n)
		st.sof |-> st.len == SOF_BASE_LEN + 16'({$past(frame_adjust), 4'h0});
	endproperty
	a_sof_len: assert property (p_sof_len) else $error("microframe length mismatch");

	property p_sof_period;
		@(posedge sys_clk) disable iff (!rst_n)
		st.sof |-> st.cnt == 16'h0000 && $past(st.cnt) == $past(st.len) - 16'h0001;
	endproperty
	a_sof_period: assert property (p_sof_period) else $error("microframe did not restart");

endmodule

// [ucfg_regs.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - grant and latency hints count 250 ns units; zero means no latency need
// - minimum grant reads 01h in full/low-speed function, 02h in high-speed
// - maximum latency reads 2Ah in full/low-speed function, 10h in high-speed
// - target-ready timeout byte at 40h, read/write, resets 00h meaning disabled
// - timeout limit is 13 bits: byte in upper eight, low five zero
// - enabled target-ready wait longer than limit sets unrecoverable error flag
// - retry limit byte at 41h, read/write, resets to 80h
// - retry limit 00h disables retry checking
// - retries on one transaction beyond the limit set unrecoverable error flag
// - high-speed function adds registers at 60h, 61h and 62h to 63h
// - release number reads 20h, fixed
// - microframe length is 59488 plus sixteen per adjustment step
// - frame adjust resets to 20h, giving 60000 counter clocks
// - new adjustment value changes following microframes
module ucfg_regs import ucfg_pkg::*; #(
	parameter bit HS_FUNCTION = 1'b1,
	parameter int WAIT_CNT_W  = 14
) (
	input  wire logic         sys_clk,                  // bus clock
	input  wire logic         rst_n,                    // async reset, active low
	input  wire ucfg_req_t    cfg_req,                  // configuration byte access
	output ucfg_rsp_t         cfg_rsp,                  // answer one cycle later
	input  wire ucfg_pci_ev_t pci_ev,                   // bus events from the core
	input  wire logic         ue_clear,                 // pulse, clears the error flag
	output logic              unrecoverable_error_flag, // sticky error
	output logic [15:0]       port_wake_mask,           // wake policy mask
	output logic [15:0]       min_grant_cycles,         // hint in clock cycles
	output logic [15:0]       max_latency_cycles,       // hint in clock cycles
	output logic [8:0]        retry_count,              // retries of this transaction
	output logic              sof_pulse,                // microframe start
	output logic [15:0]       frame_len                 // current microframe length
);

	if (WAIT_CNT_W != TRDY_LIMIT_W + 1) begin : g_chk
		$error("ucfg_regs: wait counter must be one bit wider than the 13-bit limit");
	end

	localparam logic [7:0] MIN_GRANT   = HS_FUNCTION ? MIN_GRANT_HS : MIN_GRANT_FS;
	localparam logic [7:0] MAX_LATENCY = HS_FUNCTION ? MAX_LATENCY_HS : MAX_LATENCY_FS;
	localparam logic [7:0] HINT_CYC    = 8'(HINT_UNIT_CYC);

	ucfg_st_t st;
	ucfg_st_t next_st;

	logic [WAIT_CNT_W-1:0] trdy_limit;
	logic                  trdy_hit;
	logic [8:0]            retry_next;
	logic                  retry_hit;
	logic                  wr_en;

	function automatic logic [7:0] read_byte(input logic [7:0] a, input ucfg_st_t s);
		logic [7:0] d;
		d = UNMAPPED_DATA;
		unique case (a)
			OFF_MIN_GRANT:   d = MIN_GRANT;
			OFF_MAX_LATENCY: d = MAX_LATENCY;
			OFF_TRDY_TO:     d = s.trdy_to;
			OFF_RETRY_LIM:   d = s.retry_lim;
			OFF_RELEASE:     d = HS_FUNCTION ? RELEASE_NUMBER : UNMAPPED_DATA;
			OFF_FRAME_ADJ:   d = HS_FUNCTION ? s.frame_adj : UNMAPPED_DATA;
			OFF_WAKE_LO:     d = HS_FUNCTION ? s.wake[7:0] : UNMAPPED_DATA;
			OFF_WAKE_HI:     d = HS_FUNCTION ? s.wake[15:8] : UNMAPPED_DATA;
			default:         d = UNMAPPED_DATA;
		endcase
		return d;
	endfunction

	// hints expressed as bus clock cycles for local arbitration
	assign min_grant_cycles   = 16'(MIN_GRANT) * 16'(HINT_CYC);
	assign max_latency_cycles = 16'(MAX_LATENCY) * 16'(HINT_CYC);

	assign wr_en = cfg_req.valid && cfg_req.write;

	// limit is the byte shifted up past five zero bits
	assign trdy_limit = WAIT_CNT_W'({st.trdy_to, {TRDY_ZERO_BITS{1'b0}}});

	// a zero byte turns the check off
	assign trdy_hit = (st.tw == TW_WAIT) && (st.trdy_to != RST_TRDY_TO)
		&& (st.wait_cnt > trdy_limit);

	assign retry_next = (st.retry_cnt == 9'h1FF) ? st.retry_cnt : st.retry_cnt + 9'h001;

	assign retry_hit = pci_ev.retry_term && (st.retry_lim != 8'h00)
		&& (retry_next > {1'b0, st.retry_lim});

	always_comb begin
		next_st = st;

		// register reads and writes
		next_st.rsp.ack   = cfg_req.valid;
		next_st.rsp.rdata = cfg_req.valid && !cfg_req.write ? read_byte(cfg_req.addr, st) : 8'h00;
		if (wr_en) begin
			unique case (cfg_req.addr)
				OFF_TRDY_TO:   next_st.trdy_to = cfg_req.wdata;
				OFF_RETRY_LIM: next_st.retry_lim = cfg_req.wdata;
				OFF_FRAME_ADJ: begin
					// upper two bits are stored as written; only the low six steer timing
					if (HS_FUNCTION) begin
						next_st.frame_adj = cfg_req.wdata;
					end
				end
				OFF_WAKE_LO: begin
					if (HS_FUNCTION) begin
						next_st.wake[7:0] = cfg_req.wdata;
					end
				end
				OFF_WAKE_HI: begin
					if (HS_FUNCTION) begin
						next_st.wake[15:8] = cfg_req.wdata;
					end
				end
				default: begin
				end
			endcase
		end

		// target-ready wait timer
		unique case (st.tw)
			TW_IDLE: begin
				if (pci_ev.data_phase_start && !pci_ev.target_ready) begin
					next_st.tw       = TW_WAIT;
					next_st.wait_cnt = '0;
				end
			end
			TW_WAIT: begin
				if (pci_ev.target_ready || pci_ev.txn_end) begin
					next_st.tw       = TW_IDLE;
					next_st.wait_cnt = '0;
				end else if (pci_ev.data_phase_start) begin
					next_st.wait_cnt = '0;
				end else if (st.wait_cnt != '1) begin
					next_st.wait_cnt = st.wait_cnt + WAIT_CNT_W'(1);
				end
			end
		endcase

		// retry counter
		if (pci_ev.txn_end) begin
			next_st.retry_cnt = 9'h000;
		end else if (pci_ev.retry_term) begin
			next_st.retry_cnt = retry_next;
		end

		// sticky error, a new event wins over the clear
		if (ue_clear) begin
			next_st.ue = 1'b0;
		end
		if (trdy_hit || retry_hit) begin
			next_st.ue = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st.trdy_to   <= RST_TRDY_TO;
			st.retry_lim <= RST_RETRY_LIM;
			st.frame_adj <= RST_FRAME_ADJ;
			st.wake      <= RST_WAKE_MASK;
			st.tw        <= TW_IDLE;
			st.wait_cnt  <= '0;
			st.retry_cnt <= 9'h000;
			st.ue        <= 1'b0;
			st.rsp       <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign cfg_rsp                  = st.rsp;
	assign unrecoverable_error_flag = st.ue;
	assign port_wake_mask           = st.wake;
	assign retry_count              = st.retry_cnt;

	ucfg_sof_timer #(
		.ADJ_W(FRAME_ADJ_W)
	) u_sof (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.frame_adjust(st.frame_adj[FRAME_ADJ_W-1:0]),
		.sof_pulse   (sof_pulse),
		.frame_len   (frame_len)
	);

	property p_hint_cycles;
		@(posedge sys_clk) disable iff (!rst_n)
		min_grant_cycles == 16'(MIN_GRANT) * 16'h0032 && max_latency_cycles == 16'(MAX_LATENCY) * 16'h0032;
	endproperty
	a_hint_cycles: assert property (p_hint_cycles) else $error("hint cycles wrong");

	property p_min_grant_read;
		@(posedge sys_clk) disable iff (!rst_n)
		cfg_req.valid && !cfg_req.write && cfg_req.addr == OFF_MIN_GRANT
		|=> cfg_rsp.ack && cfg_rsp.rdata == (HS_FUNCTION ? 8'h02 : 8'h01);
	endproperty
	a_min_grant_read: assert property (p_min_grant_read) else $error("minimum grant read wrong");

	property p_max_latency_read;
		@(posedge sys_clk) disable iff (!rst_n)
		cfg_req.valid && !cfg_req.write && cfg_req.addr == OFF_MAX_LATENCY
		|=> cfg_rsp.ack && cfg_rsp.rdata == (HS_FUNCTION ? 8'h10 : 8'h2A);
	endproperty
	a_max_latency_read: assert property (p_max_latency_read) else $error("maximum latency read wrong");

	property p_trdy_write;
		@(posedge sys_clk) disable iff (!rst_n)
		wr_en && cfg_req.addr == OFF_TRDY_TO ##1 !(cfg_req.valid && !cfg_req.write)
		|-> st.trdy_to == $past(cfg_req.wdata, 1);
	endproperty
	a_trdy_write: assert property (p_trdy_write) else $error("timeout byte not stored");

	property p_trdy_off;
		@(posedge sys_clk) disable iff (!rst_n)
		st.trdy_to == 8'h00 |-> !trdy_hit;
	endproperty
	a_trdy_off: assert property (p_trdy_off) else $error("disabled timeout fired");

	property p_trdy_fire;
		@(posedge sys_clk) disable iff (!rst_n)
		st.tw == TW_WAIT && st.trdy_to != 8'h00 && st.wait_cnt == {1'b0, st.trdy_to, 5'h00} + 14'h0001
		|=> unrecoverable_error_flag;
	endproperty
	a_trdy_fire: assert property (p_trdy_fire) else $error("long wait did not set error");

	property p_trdy_quiet;
		@(posedge sys_clk) disable iff (!rst_n)
		st.tw == TW_WAIT && st.wait_cnt <= {1'b0, st.trdy_to, 5'h00} && !retry_hit && !st.ue
		|=> !unrecoverable_error_flag;
	endproperty
	a_trdy_quiet: assert property (p_trdy_quiet) else $error("error set before limit");

	property p_retry_off;
		@(posedge sys_clk) disable iff (!rst_n)
		st.retry_lim == 8'h00 |-> !retry_hit;
	endproperty
	a_retry_off: assert property (p_retry_off) else $error("disabled retry check fired");

	property p_retry_fire;
		@(posedge sys_clk) disable iff (!rst_n)
		pci_ev.retry_term && st.retry_lim != 8'h00 && st.retry_cnt == {1'b0, st.retry_lim}
		|=> unrecoverable_error_flag;
	endproperty
	a_retry_fire: assert property (p_retry_fire) else $error("retry overrun did not set error");

	property p_ue_cause;
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(unrecoverable_error_flag) |-> $past(trdy_hit) || $past(retry_hit);
	endproperty
	a_ue_cause: assert property (p_ue_cause) else $error("error set without cause");

	property p_release_read;
		@(posedge sys_clk) disable iff (!rst_n)
		cfg_req.valid && !cfg_req.write && cfg_req.addr == OFF_RELEASE
		|=> cfg_rsp.rdata == (HS_FUNCTION ? 8'h20 : 8'h00);
	endproperty
	a_release_read: assert property (p_release_read) else $error("release number wrong");

	property p_wait_stop;
		@(posedge sys_clk) disable iff (!rst_n)
		pci_ev.target_ready |=> st.tw == TW_IDLE && st.wait_cnt == '0;
	endproperty
	a_wait_stop: assert property (p_wait_stop) else $error("wait timer did not stop");

	property p_retry_clear;
		@(posedge sys_clk) disable iff (!rst_n)
		pci_ev.txn_end |=> retry_count == 9'h000;
	endproperty
	a_retry_clear: assert property (p_retry_clear) else $error("retry count not cleared");

	property p_retry_count;
		@(posedge sys_clk) disable iff (!rst_n)
		pci_ev.retry_term && !pci_ev.txn_end && retry_count != 9'h1FF
		|=> retry_count == $past(retry_count) + 9'h001;
	endproperty
	a_retry_count: assert property (p_retry_count) else $error("retry not counted");

	property p_frame_follow;
		@(posedge sys_clk) disable iff (!rst_n)
		sof_pulse |-> frame_len == 16'hE860 + 16'({$past(st.frame_adj[5:0]), 4'h0});
	endproperty
	a_frame_follow: assert property (p_frame_follow) else $error("frame length ignores adjust");

endmodule

// [ucfg_bridge_model.sv]
`timescale 1ns/1ps
module ucfg_bridge_model import ucfg_pkg::*; (
	input  wire logic    sys_clk, // bus clock
	output ucfg_pci_ev_t pci_ev   // bus events toward the block
);
	initial pci_ev = '0;

	// data phase whose target answers ready w cycles after the start
	task automatic data_phase(input int w);
		@(posedge sys_clk) pci_ev.data_phase_start <= 1'b1;
		@(posedge sys_clk) pci_ev.data_phase_start <= 1'b0;
		repeat (w - 1) @(posedge sys_clk);
		pci_ev.target_ready <= 1'b1;
		@(posedge sys_clk) pci_ev.target_ready <= 1'b0;
	endtask

	// n retry terminations, then optionally the transaction is abandoned
	task automatic retries(input int n, input bit fin);
		repeat (n) begin
			@(posedge sys_clk) pci_ev.retry_term <= 1'b1;
			@(posedge sys_clk) pci_ev.retry_term <= 1'b0;
		end
		if (fin) begin
			@(posedge sys_clk) pci_ev.txn_end <= 1'b1;
			@(posedge sys_clk) pci_ev.txn_end <= 1'b0;
		end
	endtask
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_top import ucfg_pkg::*;;
	typedef struct packed {
		logic       wr;
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] e;
		logic [7:0] f;
	} ucfg_row_t;

	logic         sys_clk;
	logic         rst_n;
	ucfg_req_t    cfg_req;
	ucfg_rsp_t    cfg_rsp;
	ucfg_pci_ev_t pci_ev;
	logic         ue_clear;
	logic         ue_flag;
	logic [15:0]  wake;
	logic [15:0]  min_cyc;
	logic [15:0]  max_cyc;
	logic [8:0]   rcnt;
	logic         sof;
	logic [15:0]  flen;
	ucfg_rsp_t    cfg_rsp_fs;
	logic [15:0]  min_cyc_fs;
	logic [15:0]  max_cyc_fs;
	int           fail_count;
	int           n_tests;
	int           cyc;
	int           rel;
	ucfg_row_t    rows [18];

	ucfg_regs i_ucfg_regs (
		.sys_clk                  (sys_clk),
		.rst_n                    (rst_n),
		.cfg_req                  (cfg_req),
		.cfg_rsp                  (cfg_rsp),
		.pci_ev                   (pci_ev),
		.ue_clear                 (ue_clear),
		.unrecoverable_error_flag (ue_flag),
		.port_wake_mask           (wake),
		.min_grant_cycles         (min_cyc),
		.max_latency_cycles       (max_cyc),
		.retry_count              (rcnt),
		.sof_pulse                (sof),
		.frame_len                (flen)
	);

	// full/low-speed build on the same bus and events
	ucfg_regs #(
		.HS_FUNCTION(1'b0)
	) i_ucfg_regs_fs (
		.sys_clk                  (sys_clk),
		.rst_n                    (rst_n),
		.cfg_req                  (cfg_req),
		.cfg_rsp                  (cfg_rsp_fs),
		.pci_ev                   (pci_ev),
		.ue_clear                 (ue_clear),
		.unrecoverable_error_flag (),
		.port_wake_mask           (),
		.min_grant_cycles         (min_cyc_fs),
		.max_latency_cycles       (max_cyc_fs),
		.retry_count              (),
		.sof_pulse                (),
		.frame_len                ()
	);

	ucfg_bridge_model i_ucfg_bridge_model (
		.sys_clk (sys_clk),
		.pci_ev  (pci_ev)
	);

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc > 70000) begin
			fail_count++;
			summarize();
		end
	end

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
		@(posedge sys_clk) cfg_req <= '{1'b1, wr, a, d};
		@(posedge sys_clk) cfg_req.valid <= 1'b0;
		#1;
		`CHK("ack", 1'b1, cfg_rsp.ack)
		`CHK("rdata", e, cfg_rsp.rdata)
	endtask

	task automatic clr();
		@(posedge sys_clk) ue_clear <= 1'b1;
		@(posedge sys_clk) ue_clear <= 1'b0;
		#1;
		`CHK("flag cleared", 1'b0, ue_flag)
	endtask

	task automatic flag_after(input logic e, input string nm);
		repeat (3) @(posedge sys_clk);
		#1;
		`CHK("error flag", e, ue_flag)
		$display("test %s done", nm);
	endtask

	initial begin
		rows = '{
			'{1'b0, 8'h3E, 8'h00, 8'h02, 8'h01}, '{1'b0, 8'h3F, 8'h00, 8'h10, 8'h2A},
			'{1'b0, 8'h40, 8'h00, 8'h00, 8'h00}, '{1'b0, 8'h41, 8'h00, 8'h80, 8'h80},
			'{1'b0, 8'h60, 8'h00, 8'h20, 8'h00}, '{1'b0, 8'h61, 8'h00, 8'h20, 8'h00},
			'{1'b0, 8'h62, 8'h00, 8'h07, 8'h00}, '{1'b0, 8'h63, 8'h00, 8'h00, 8'h00},
			'{1'b1, 8'h40, 8'h01, 8'h00, 8'h00}, '{1'b0, 8'h40, 8'h00, 8'h01, 8'h01},
			'{1'b1, 8'h3E, 8'h55, 8'h00, 8'h00}, '{1'b0, 8'h3E, 8'h00, 8'h02, 8'h01},
			'{1'b1, 8'h60, 8'h00, 8'h00, 8'h00}, '{1'b0, 8'h60, 8'h00, 8'h20, 8'h00},
			'{1'b1, 8'h62, 8'hA5, 8'h00, 8'h00}, '{1'b0, 8'h62, 8'h00, 8'hA5, 8'h00},
			'{1'b1, 8'h50, 8'h77, 8'h00, 8'h00}, '{1'b0, 8'h50, 8'h00, 8'h00, 8'h00}};
		cfg_req = '0;
		ue_clear = 1'b0;
		rst_n = 1'b0;
		fail_count = 0;
		n_tests = 0;
		cyc = 0;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			acc(rows[i].wr, rows[i].a, rows[i].d, rows[i].e);
			`CHK("rdata fs", rows[i].f, cfg_rsp_fs.rdata)
		end
		`CHK("min grant cycles", 16'(MIN_GRANT_HS) * 16'(HINT_UNIT_CYC), min_cyc)
		`CHK("max latency cycles", 16'(MAX_LATENCY_HS) * 16'(HINT_UNIT_CYC), max_cyc)
		`CHK("min grant cycles fs", 16'(MIN_GRANT_FS) * 16'(HINT_UNIT_CYC), min_cyc_fs)
		`CHK("max latency cycles fs", 16'(MAX_LATENCY_FS) * 16'(HINT_UNIT_CYC), max_cyc_fs)
		$display("test register table done");

		// second reset in mid-run restores the defaults
		@(posedge sys_clk) rst_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		#1;
		rel = cyc;
		`CHK("wake mask", 16'h0007, wake)
		`CHK("frame len", 16'hEA60, flen)
		`CHK("retry count", 9'h000, rcnt)
		`CHK("error flag", 1'b0, ue_flag)
		acc(1'b0, 8'h40, 8'h00, 8'h00);
		acc(1'b0, 8'h41, 8'h00, 8'h80);
		$display("test reset done");

		// limit 32: ready on the 33rd cycle still passes, on the 34th the count has gone past 32
		acc(1'b1, 8'h40, 8'h01, 8'h00);
		i_ucfg_bridge_model.data_phase(33);
		flag_after(1'b0, "wait at limit");
		i_ucfg_bridge_model.data_phase(34);
		flag_after(1'b1, "wait over limit");
		clr();
		acc(1'b1, 8'h40, 8'h00, 8'h00);
		i_ucfg_bridge_model.data_phase(40);
		flag_after(1'b0, "wait check disabled");

		acc(1'b1, 8'h41, 8'h02, 8'h00);
		i_ucfg_bridge_model.retries(2, 1'b0);
		#1;
		`CHK("retry count", 9'h002, rcnt)
		i_ucfg_bridge_model.retries(0, 1'b1);
		#1;
		`CHK("retry count", 9'h000, rcnt)
		flag_after(1'b0, "retries at limit");
		i_ucfg_bridge_model.retries(3, 1'b1);
		flag_after(1'b1, "retries over limit");
		clr();
		acc(1'b1, 8'h41, 8'h00, 8'h00);
		i_ucfg_bridge_model.retries(5, 1'b1);
		flag_after(1'b0, "retry check disabled");

		// bits 7:6 written as zero, largest adjustment
		acc(1'b1, 8'h61, 8'h3F, 8'h00);
		acc(1'b0, 8'h61, 8'h00, 8'h3F);
		while (sof !== 1'b1) begin
			@(posedge sys_clk);
			#1;
		end
		`CHK("first microframe 60000", 1'b1, (cyc - rel) == 60000)
		`CHK("next frame len", 16'd59488 + 16'd16 * 16'd63, flen)
		@(posedge sys_clk);
		#1;
		`CHK("sof pulse width", 1'b0, sof)
		$display("test microframe done");
		summarize();
	end
endmodule
